// file: core/psx_issue_check.sv
// issue-time checker for packed-integer simd instructions
// Operation
// - pending fp exception faults vector 16, error pin
// - faulting instruction reissues after handler returns
// - no numeric fault without pending exception
// - memory faults reported like other instructions
// - address-size prefix needs memory operand
// - segment override needs memory operand
// - lock prefix always gives invalid opcode
// - operand-size, repeat, hint prefixes are reserved; the code treats hint bytes 2e/3e as CS/DS segment overrides
// - simd registers share fp storage and tags
// - non-empty op zeroes stack top, tags valid
// - simd register write sets exponent all ones
// - unsupported or emulation set gives invalid opcode
// - state-empty op marks every tag empty
//
// Added by the designer: the register addresses and the strobed register port.
`default_nettype none

module psx_issue_check #(
  parameter int unsigned NUM_PREFIX = 4
) (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic [7:0]                 regAddr,
  input  wire logic [31:0]                regWrData,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [31:0]                regRdData,
  output logic                            irq,
  input  wire logic                       issueValid,
  input  wire logic                       issueMemOp,
  input  wire logic                       issueEmptyOp,
  input  wire logic                       issueWritesReg,
  input  wire logic [2:0]                 issueDstIdx,
  input  wire logic [63:0]                issueData,
  input  wire logic                       issueMemFault,
  input  wire logic [1:0]                 issueMemFaultKind,
  input  wire logic [NUM_PREFIX-1:0][7:0] prefixBytes,
  input  wire logic [NUM_PREFIX-1:0]      prefixValid,
  input  wire logic                       fpExcRaise,
  input  wire logic                       fpExcClear,
  input  wire logic                       fpuWrEn,
  input  wire logic [2:0]                 fpuWrIdx,
  input  wire logic [79:0]                fpuWrData,
  input  wire logic                       fpuTagWrEn,
  input  wire logic [15:0]                fpuTagData,
  input  wire logic                       fpuTopWrEn,
  input  wire logic [2:0]                 fpuTopData,
  input  wire logic [2:0]                 simdRdIdx,
  output logic      [79:0]                simdRdData,
  output logic      [15:0]                tagWord,
  output logic      [2:0]                 stackTop,
  output logic                            resultValid,
  output logic                            resultInvalid,
  output logic                            resultNumeric,
  output logic                            resultMemFault,
  output logic      [1:0]                 resultMemKind,
  output logic      [7:0]                 resultVector,
  output logic                            resultUseAddrSize,
  output logic                            resultSegValid,
  output logic      [2:0]                 resultSegSelect,
  output logic                            fp_error_out_n
);
  logic       hasLock;
  logic       hasAddrSize;
  logic       hasSegment;
  logic       hasAlwaysRsv;
  logic [2:0] segSelect;

  psx_prefix_decode #(
    .NUM_PREFIX (NUM_PREFIX)
  ) u_prefix (
    .prefixBytes       (prefixBytes),
    .prefixValid       (prefixValid),
    .hasLock           (hasLock),
    .hasAddrSize       (hasAddrSize),
    .hasSegment        (hasSegment),
    .hasAlwaysReserved (hasAlwaysRsv),
    .segSelect         (segSelect)
  );

  // control, interrupt and pending state
  logic [2:0]                     ctrl_q;
  logic [2:0]                     ctrl_d;
  logic [psx_pkg::EV_COUNT-1:0]   status_q;
  logic [psx_pkg::EV_COUNT-1:0]   status_d;
  logic [psx_pkg::EV_COUNT-1:0]   intEn_q;
  logic [psx_pkg::EV_COUNT-1:0]   intEn_d;
  logic [psx_pkg::EV_COUNT-1:0]   events;
  logic [31:0]                    rdData_d;
  logic                           pending_q;
  logic                           pending_d;
  psx_pkg::psx_fp_error_out_n_e             fp_error_out_n_q;
  psx_pkg::psx_fp_error_out_n_e             fp_error_out_n_d;

  // issue decision
  logic rsvHit;
  logic udHit;
  logic numHit;
  logic memHit;
  logic commitValid;

  // priority: invalid opcode, then numeric error, then memory fault, else commit
  always_comb begin
    rsvHit = hasAlwaysRsv ||
             (!issueMemOp && (hasAddrSize || hasSegment));
    udHit  = hasLock ||
             ctrl_q[psx_pkg::CTRL_EMUL_BIT] ||
             !ctrl_q[psx_pkg::CTRL_ENABLE_BIT] ||
             (rsvHit && ctrl_q[psx_pkg::CTRL_RSVUD_BIT]);
    // the flag as registered is checked, so nothing commits past a pending error
    numHit = !udHit && pending_q;
    memHit = !udHit && !pending_q && issueMemFault;
    commitValid = issueValid && !udHit && !numHit && !memHit;
  end

  psx_fp_alias_file #(
    .NUM_REGS (8),
    .DATA_W   (64),
    .EXP_W    (16)
  ) u_alias (
    .clock       (clock),
    .resetn      (resetn),
    .commitValid (commitValid),
    .commitEmpty (issueEmptyOp),
    .commitWrite (issueWritesReg),
    .commitIdx   (issueDstIdx),
    .commitData  (issueData),
    .fpuWrEn     (fpuWrEn),
    .fpuWrIdx    (fpuWrIdx),
    .fpuWrData   (fpuWrData),
    .fpuTagWrEn  (fpuTagWrEn),
    .fpuTagData  (fpuTagData),
    .fpuTopWrEn  (fpuTopWrEn),
    .fpuTopData  (fpuTopData),
    .rdIdx       (simdRdIdx),
    .rdData      (simdRdData),
    .tagWord     (tagWord),
    .stackTop    (stackTop)
  );

  // result record, one cycle after issue; a faulted op changes no state so
  // the front end simply reissues it once the handler clears the flag
  logic       resValid_d;
  logic       resInv_d;
  logic       resNum_d;
  logic       resMem_d;
  logic [1:0] resKind_d;
  logic [7:0] resVec_d;
  logic       resAddr_d;
  logic       resSeg_d;
  logic [2:0] resSegSel_d;

  always_comb begin
    resValid_d  = issueValid;
    resInv_d    = issueValid && udHit;
    resNum_d    = issueValid && numHit;
    resMem_d    = issueValid && memHit;
    resKind_d   = memHit ? issueMemFaultKind : 2'h0;
    resVec_d    = 8'h00;
    if (issueValid && udHit) begin
      resVec_d = psx_pkg::VEC_INVALID;
    end else if (issueValid && numHit) begin
      resVec_d = psx_pkg::VEC_NUMERIC;
    end
    resAddr_d   = commitValid && issueMemOp && hasAddrSize;
    resSeg_d    = commitValid && issueMemOp && hasSegment;
    resSegSel_d = resSeg_d ? segSelect : psx_pkg::SEG_DS;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resultValid       <= 1'b0;
      resultInvalid     <= 1'b0;
      resultNumeric     <= 1'b0;
      resultMemFault    <= 1'b0;
      resultMemKind     <= 2'h0;
      resultVector      <= 8'h00;
      resultUseAddrSize <= 1'b0;
      resultSegValid    <= 1'b0;
      resultSegSelect   <= psx_pkg::SEG_DS;
    end else begin
      resultValid       <= resValid_d;
      resultInvalid     <= resInv_d;
      resultNumeric     <= resNum_d;
      resultMemFault    <= resMem_d;
      resultMemKind     <= resKind_d;
      resultVector      <= resVec_d;
      resultUseAddrSize <= resAddr_d;
      resultSegValid    <= resSeg_d;
      resultSegSelect   <= resSegSel_d;
    end
  end

  // sticky pending flag and error pin; a raise in the clear cycle survives
  always_comb begin
    pending_d = fpExcRaise || (pending_q && !fpExcClear);
    fp_error_out_n_d    = fp_error_out_n_q;
    unique case (fp_error_out_n_q)
      psx_pkg::FP_ERROR_OUT_N_IDLE: begin
        if (issueValid && numHit) begin
          fp_error_out_n_d = psx_pkg::FP_ERROR_OUT_N_ACTIVE;
        end
      end
      psx_pkg::FP_ERROR_OUT_N_ACTIVE: begin
        if (fpExcClear && !fpExcRaise) begin
          fp_error_out_n_d = psx_pkg::FP_ERROR_OUT_N_IDLE;
        end
      end
      default: fp_error_out_n_d = psx_pkg::FP_ERROR_OUT_N_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
      fp_error_out_n_q    <= psx_pkg::FP_ERROR_OUT_N_IDLE;
    end else begin
      pending_q <= pending_d;
      fp_error_out_n_q    <= fp_error_out_n_d;
    end
  end

  assign fp_error_out_n = (fp_error_out_n_q != psx_pkg::FP_ERROR_OUT_N_ACTIVE);

  // register file; status bits set wins over a clear in the same cycle
  always_comb begin
    events                         = '0;
    events[psx_pkg::EV_INVALID]    = issueValid && udHit;
    events[psx_pkg::EV_NUMERIC]    = issueValid && numHit;
    events[psx_pkg::EV_MEMFAULT]   = issueValid && memHit;
    events[psx_pkg::EV_RESERVED]   = issueValid && rsvHit;
    ctrl_d   = ctrl_q;
    intEn_d  = intEn_q;
    status_d = status_q;
    if (regWr && regAddr == psx_pkg::REG_CTRL) begin
      ctrl_d = regWrData[2:0];
    end
    if (regWr && regAddr == psx_pkg::REG_INT_EN) begin
      intEn_d = regWrData[psx_pkg::EV_COUNT-1:0];
    end
    if (regWr && regAddr == psx_pkg::REG_INT_CLR) begin
      status_d = status_q & ~regWrData[psx_pkg::EV_COUNT-1:0];
    end
    status_d = status_d | events;
    rdData_d = 32'h0000_0000;
    if (regRd) begin
      unique case (regAddr)
        psx_pkg::REG_CTRL:    rdData_d[2:0] = ctrl_q;
        psx_pkg::REG_STATUS:  rdData_d[psx_pkg::EV_COUNT-1:0] = status_q;
        psx_pkg::REG_INT_EN:  rdData_d[psx_pkg::EV_COUNT-1:0] = intEn_q;
        psx_pkg::REG_FPSTATE: begin
          rdData_d[psx_pkg::FPS_TAG_LSB +: 16] = tagWord;
          rdData_d[psx_pkg::FPS_TOP_LSB +: 3]  = stackTop;
          rdData_d[psx_pkg::FPS_PEND_BIT]      = pending_q;
        end
        default:              rdData_d = 32'h0000_0000; // unmapped and write-only
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q    <= psx_pkg::CTRL_RESET;
      intEn_q   <= '0;
      status_q  <= '0;
      regRdData <= 32'h0000_0000;
    end else begin
      ctrl_q    <= ctrl_d;
      intEn_q   <= intEn_d;
      status_q  <= status_d;
      regRdData <= rdData_d;
    end
  end

  assign irq = |(status_q & intEn_q);

  // checks on the issue path
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_pending_numeric: assert property (
    issueValid && pending_q && !udHit |=> resultNumeric && resultVector == 8'h10 && !fp_error_out_n
  ) else $error("pending fp exception did not raise numeric error");
  a_numeric_cause: assert property (
    resultNumeric |-> $past(pending_q) && $past(issueValid)
  ) else $error("numeric error raised with nothing pending");
  a_no_commit_pending: assert property (
    issueValid && pending_q |-> !commitValid ##1 $stable(tagWord)
  ) else $error("state changed while fp exception pending");
  a_mem_fault_kind: assert property (
    issueValid && issueMemFault && !udHit && !pending_q
      |=> resultMemFault && resultMemKind == $past(issueMemFaultKind)
  ) else $error("memory fault not reported");
  a_lock_invalid: assert property (
    issueValid && hasLock |=> resultInvalid && resultVector == 8'h06
  ) else $error("lock prefix did not fault");
  a_emul_invalid: assert property (
    issueValid && ctrl_q[0] |=> resultInvalid && !resultNumeric
  ) else $error("emulation bit did not fault");
  a_addr_mem_only: assert property (
    resultUseAddrSize |-> $past(issueMemOp) && $past(hasAddrSize)
  ) else $error("address size applied without memory operand");
  a_seg_select: assert property (
    commitValid && issueMemOp && hasSegment |=> resultSegValid && resultSegSelect == $past(segSelect)
  ) else $error("segment override not applied");
  a_state_valid: assert property (
    commitValid && !issueEmptyOp |=> stackTop == 3'h0 && tagWord == 16'h0000
  ) else $error("simd op left stack top or tags wrong");
  a_state_empty: assert property (
    commitValid && issueEmptyOp |=> tagWord == 16'hffff
  ) else $error("state-empty op did not empty tags");
  a_exp_ones: assert property (
    commitValid && !issueEmptyOp && issueWritesReg && simdRdIdx == issueDstIdx
      |=> ##1 simdRdData[79:64] == 16'hffff
  ) else $error("simd write left exponent not all ones");

  c_numeric_fault: cover property (issueValid && pending_q ##1 resultNumeric);
  c_lock_fault: cover property (issueValid && hasLock ##1 resultInvalid);
  c_seg_commit: cover property (commitValid && issueMemOp && hasSegment);
  c_empty_after_op: cover property (commitValid && !issueEmptyOp ##[1:4] commitValid && issueEmptyOp);
endmodule // psx_issue_check

`default_nettype wire

// file: core/psx_pkg.sv
// shared constants for the packed-integer simd prefix and exception checker
`default_nettype none

package psx_pkg;
  // legacy prefix byte codes
  localparam logic [7:0] PFX_ADDR_SIZE = 8'h67;
  localparam logic [7:0] PFX_OPER_SIZE = 8'h66;
  localparam logic [7:0] PFX_SEG_ES    = 8'h26;
  localparam logic [7:0] PFX_SEG_CS    = 8'h2e; // also branch-not-taken hint
  localparam logic [7:0] PFX_SEG_SS    = 8'h36;
  localparam logic [7:0] PFX_SEG_DS    = 8'h3e; // also branch-taken hint
  localparam logic [7:0] PFX_SEG_FS    = 8'h64;
  localparam logic [7:0] PFX_SEG_GS    = 8'h65;
  localparam logic [7:0] PFX_REP       = 8'hf3;
  localparam logic [7:0] PFX_REPNE     = 8'hf2;
  localparam logic [7:0] PFX_LOCK      = 8'hf0;

  // segment select codes handed to address generation
  localparam logic [2:0] SEG_ES = 3'h0;
  localparam logic [2:0] SEG_CS = 3'h1;
  localparam logic [2:0] SEG_SS = 3'h2;
  localparam logic [2:0] SEG_DS = 3'h3;
  localparam logic [2:0] SEG_FS = 3'h4;
  localparam logic [2:0] SEG_GS = 3'h5;

  // exception vectors and fp state encodings
  localparam logic [7:0]  VEC_NUMERIC   = 8'h10; // numeric error, vector 16
  localparam logic [7:0]  VEC_INVALID   = 8'h06; // invalid opcode
  localparam logic [1:0]  TAG_VALID     = 2'h0;
  localparam logic [1:0]  TAG_EMPTY     = 2'h3;
  localparam logic [2:0]  TOP_AFTER_OP  = 3'h0;
  localparam logic [15:0] EXP_ALL_ONES  = 16'hffff;
  localparam logic [15:0] TAGWORD_RESET = 16'hffff;
  localparam logic [2:0]  TOP_RESET     = 3'h0;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_INT_EN  = 8'h08;
  localparam logic [7:0] REG_INT_CLR = 8'h0c;
  localparam logic [7:0] REG_FPSTATE = 8'h10;

  // control register fields and reset value
  localparam int unsigned CTRL_EMUL_BIT   = 0; // fp_emulation_ctrl
  localparam int unsigned CTRL_ENABLE_BIT = 1; // simd instructions supported
  localparam int unsigned CTRL_RSVUD_BIT  = 2; // reserved prefixes fault
  localparam logic [2:0]  CTRL_RESET      = 3'h2;

  // event bits shared by status, enable and clear registers
  localparam int unsigned EV_INVALID  = 0;
  localparam int unsigned EV_NUMERIC  = 1;
  localparam int unsigned EV_MEMFAULT = 2;
  localparam int unsigned EV_RESERVED = 3;
  localparam int unsigned EV_COUNT    = 4;

  // fp state register fields
  localparam int unsigned FPS_TAG_LSB  = 0;
  localparam int unsigned FPS_TOP_LSB  = 16;
  localparam int unsigned FPS_PEND_BIT = 20;

  typedef enum logic [1:0] {
    FP_ERROR_OUT_N_IDLE   = 2'b01,
    FP_ERROR_OUT_N_ACTIVE = 2'b10
  } psx_fp_error_out_n_e;
endpackage : psx_pkg

`default_nettype wire

// file: core/psx_prefix_decode.sv
// classifies the legacy prefix bytes ahead of a packed-integer simd opcode
`default_nettype none

module psx_prefix_decode #(
  parameter int unsigned NUM_PREFIX = 4
) (
  input  wire logic [NUM_PREFIX-1:0][7:0] prefixBytes,
  input  wire logic [NUM_PREFIX-1:0]      prefixValid,
  output logic                            hasLock,
  output logic                            hasAddrSize,
  output logic                            hasSegment,
  output logic                            hasAlwaysReserved,
  output logic [2:0]                      segSelect
);
  initial begin
    if (NUM_PREFIX < 1 || NUM_PREFIX > 14) begin
      $error("psx_prefix_decode: NUM_PREFIX out of range");
    end
  end

  logic [NUM_PREFIX-1:0]      isLock;
  logic [NUM_PREFIX-1:0]      isAddr;
  logic [NUM_PREFIX-1:0]      isSeg;
  logic [NUM_PREFIX-1:0]      isRsv;
  logic [NUM_PREFIX-1:0][2:0] segCode;

  // per-byte classification
  for (genvar i = 0; i < NUM_PREFIX; i++) begin : g_byte
    always_comb begin
      isLock[i]  = prefixValid[i] && (prefixBytes[i] == psx_pkg::PFX_LOCK);
      isAddr[i]  = prefixValid[i] && (prefixBytes[i] == psx_pkg::PFX_ADDR_SIZE);
      isRsv[i]   = prefixValid[i] && ((prefixBytes[i] == psx_pkg::PFX_OPER_SIZE) ||
                                      (prefixBytes[i] == psx_pkg::PFX_REP) ||
                                      (prefixBytes[i] == psx_pkg::PFX_REPNE));
      isSeg[i]   = prefixValid[i];
      segCode[i] = psx_pkg::SEG_DS;
      unique case (prefixBytes[i])
        psx_pkg::PFX_SEG_ES: segCode[i] = psx_pkg::SEG_ES;
        psx_pkg::PFX_SEG_CS: segCode[i] = psx_pkg::SEG_CS;
        psx_pkg::PFX_SEG_SS: segCode[i] = psx_pkg::SEG_SS;
        psx_pkg::PFX_SEG_DS: segCode[i] = psx_pkg::SEG_DS;
        psx_pkg::PFX_SEG_FS: segCode[i] = psx_pkg::SEG_FS;
        psx_pkg::PFX_SEG_GS: segCode[i] = psx_pkg::SEG_GS;
        default:             isSeg[i]   = 1'b0;
      endcase
    end
  end

  // reduce; the last segment override in byte order wins, as in the general decoder
  always_comb begin
    hasLock           = |isLock;
    hasAddrSize       = |isAddr;
    hasSegment        = |isSeg;
    hasAlwaysReserved = |isRsv;
    segSelect         = psx_pkg::SEG_DS;
    for (int unsigned k = 0; k < NUM_PREFIX; k++) begin
      if (isSeg[k]) begin
        segSelect = segCode[k];
      end
    end
  end
endmodule // psx_prefix_decode

`default_nettype wire

// file: core/psx_fp_alias_file.sv
// shared data registers, tag word and stack top seen by both fp and simd ops
`default_nettype none

module psx_fp_alias_file #(
  parameter int unsigned NUM_REGS = 8,
  parameter int unsigned DATA_W   = 64,
  parameter int unsigned EXP_W    = 16
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        commitValid,
  input  wire logic                        commitEmpty,
  input  wire logic                        commitWrite,
  input  wire logic [$clog2(NUM_REGS)-1:0] commitIdx,
  input  wire logic [DATA_W-1:0]           commitData,
  input  wire logic                        fpuWrEn,
  input  wire logic [$clog2(NUM_REGS)-1:0] fpuWrIdx,
  input  wire logic [DATA_W+EXP_W-1:0]     fpuWrData,
  input  wire logic                        fpuTagWrEn,
  input  wire logic [2*NUM_REGS-1:0]       fpuTagData,
  input  wire logic                        fpuTopWrEn,
  input  wire logic [$clog2(NUM_REGS)-1:0] fpuTopData,
  input  wire logic [$clog2(NUM_REGS)-1:0] rdIdx,
  output logic      [DATA_W+EXP_W-1:0]     rdData,
  output logic      [2*NUM_REGS-1:0]       tagWord,
  output logic      [$clog2(NUM_REGS)-1:0] stackTop
);
  initial begin
    if (NUM_REGS != 8 || EXP_W != 16 || DATA_W != 64) begin
      $error("psx_fp_alias_file: layout must be 8 x (64 + 16) bits");
    end
  end

  localparam int unsigned IDX_W = $clog2(NUM_REGS);

  logic [NUM_REGS-1:0][DATA_W+EXP_W-1:0] regs_q;
  logic [NUM_REGS-1:0][DATA_W+EXP_W-1:0] regs_d;
  logic [2*NUM_REGS-1:0]                 tag_q;
  logic [2*NUM_REGS-1:0]                 tag_d;
  logic [IDX_W-1:0]                      top_q;
  logic [IDX_W-1:0]                      top_d;
  logic [DATA_W+EXP_W-1:0]               rd_d;

  // one storage for both views; a simd write marks the exponent all ones
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    always_comb begin
      regs_d[r] = regs_q[r];
      if (commitValid && !commitEmpty && commitWrite && commitIdx == IDX_W'(r)) begin
        regs_d[r] = {psx_pkg::EXP_ALL_ONES, commitData};
      end else if (fpuWrEn && fpuWrIdx == IDX_W'(r)) begin
        regs_d[r] = fpuWrData;
      end
    end
  end

  // simd commit outranks the fpu port, they never overlap in a legal program
  always_comb begin
    tag_d = tag_q;
    top_d = top_q;
    rd_d  = regs_q[rdIdx];
    if (commitValid && commitEmpty) begin
      tag_d = {NUM_REGS{psx_pkg::TAG_EMPTY}};
    end else if (commitValid) begin
      tag_d = {NUM_REGS{psx_pkg::TAG_VALID}};
      top_d = psx_pkg::TOP_AFTER_OP;
    end else begin
      if (fpuTagWrEn) begin
        tag_d = fpuTagData;
      end
      if (fpuTopWrEn) begin
        top_d = fpuTopData;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regs_q <= '0;
      tag_q  <= psx_pkg::TAGWORD_RESET;
      top_q  <= psx_pkg::TOP_RESET;
      rdData <= '0;
    end else begin
      regs_q <= regs_d;
      tag_q  <= tag_d;
      top_q  <= top_d;
      rdData <= rd_d;
    end
  end

  assign tagWord  = tag_q;
  assign stackTop = top_q;
endmodule // psx_fp_alias_file

`default_nettype wire

// file: sim/psx_fpu_model.sv
// fpu partner model: exception pulses and direct register, tag and top writes
`default_nettype none
module psx_fpu_model (
  input  wire logic        clock,
  output logic             fpExcRaise,
  output logic             fpExcClear,
  output logic             fpuWrEn,
  output logic      [2:0]  fpuWrIdx,
  output logic      [79:0] fpuWrData,
  output logic             fpuTagWrEn,
  output logic      [15:0] fpuTagData,
  output logic             fpuTopWrEn,
  output logic      [2:0]  fpuTopData
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet between requests; every strobe lasts exactly one cycle
  initial {fpExcRaise, fpExcClear, fpuWrEn, fpuTagWrEn, fpuTopWrEn} = '0;
  initial {fpuWrIdx, fpuWrData, fpuTagData, fpuTopData} = '0;
  // raise or clear the pending exception for one cycle
  task automatic pulse(input logic r, input logic c);
    @(posedge clock);
    fpExcRaise <= r;
    fpExcClear <= c;
    @(posedge clock);
    fpExcRaise <= 1'b0;
    fpExcClear <= 1'b0;
  endtask
  // one cycle writing register, tag word and stack top; top reuses the index
  task automatic load(input logic [2:0] i, input logic [79:0] v, input logic [15:0] t);
    @(posedge clock);
    {fpuWrEn, fpuTagWrEn, fpuTopWrEn} <= 3'h7;
    fpuWrIdx <= i;
    fpuWrData <= v;
    fpuTagData <= t;
    fpuTopData <= i;
    @(posedge clock);
    {fpuWrEn, fpuTagWrEn, fpuTopWrEn} <= 3'h0;
  endtask
endmodule // psx_fpu_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the simd prefix and exception checker
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, resetn = 0, regWr = 0, regRd = 0, irq;
  logic [7:0]  regAddr = '0, resultVector, ev;
  logic [31:0] regWrData = '0, regRdData, rv;
  logic        issueValid = 0, issueMemOp = 0, issueEmptyOp = 0, issueWritesReg = 0;
  logic        issueMemFault = 0, resultValid, resultInvalid, resultNumeric, resultMemFault;
  logic [1:0]  issueMemFaultKind = '0, resultMemKind;
  logic [2:0]  issueDstIdx = '0, simdRdIdx, stackTop, resultSegSelect, fpuWrIdx, fpuTopData;
  logic [63:0] issueData = '0;
  logic [3:0][7:0] prefixBytes = '0;
  logic [3:0]  prefixValid = '0;
  logic        fpExcRaise, fpExcClear, fpuWrEn, fpuTagWrEn, fpuTopWrEn;
  logic        resultUseAddrSize, resultSegValid, fp_error_out_n;
  logic [79:0] fpuWrData, simdRdData, fd;
  logic [15:0] fpuTagData, tagWord;
  int          bad_count = 0, check_count = 0, cyc = 0;
  logic [7:0]  pfx [11] = '{8'hf0, 8'h66, 8'hf3, 8'hf2, 8'h67, 8'h26, 8'h2e, 8'h36, 8'h3e,
                            8'h64, 8'h65};
  logic [2:0]  cv [4] = '{3'h2, 3'h6, 3'h3, 3'h0}; // ignore, fault, emulation, unsupported
  assign simdRdIdx = issueDstIdx;
  psx_issue_check #(.NUM_PREFIX(4)) psx_issue_check_i (.*);
  psx_fpu_model psx_fpu_model_i (.*);
  always #5 clock = ~clock;
  // hang guard: far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 rv = regRdData;
  endtask
  // one issue with a single prefix byte (0 means none); results sampled after the answer
  task automatic iss(input logic w, input logic m, input logic e, input logic f,
                     input logic [7:0] p);
    @(posedge clock);
    {issueValid, issueWritesReg, issueMemOp, issueEmptyOp, issueMemFault} <= {1'b1, w, m, e, f};
    issueMemFaultKind <= 2'($urandom);
    issueDstIdx <= 3'($urandom);
    issueData <= {$urandom, $urandom};
    prefixBytes <= {24'h0, p};
    prefixValid <= {3'h0, p != 8'h00};
    @(posedge clock);
    issueValid <= 1'b0;
    #1;
  endtask
  // lock always faults; reserved forms fault only when ctrl bit2 asks for it
  function automatic logic [7:0] vecFor(input logic [7:0] p, input logic m, input logic [2:0] c);
    logic rsv;
    rsv = (p inside {8'h66, 8'hf3, 8'hf2}) || (!m && p != 8'hf0);
    if (p == 8'hf0 || c[0] || !c[1] || (rsv && c[2])) return 8'h06;
    return 8'h00;
  endfunction
  function automatic logic [2:0] segFor(input logic [7:0] p);
    return p == 8'h26 ? 3'h0 : p == 8'h2e ? 3'h1 : p == 8'h36 ? 3'h2 :
           p == 8'h64 ? 3'h4 : p == 8'h65 ? 3'h5 : 3'h3;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rv = $urandom(32'h2d15);
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    #1 chk({tagWord, stackTop, fp_error_out_n}, {16'hffff, 3'h0, 1'b1});
    rd(8'h00);
    chk(rv, 32'h2);
    rd(8'h3c);
    chk(rv, 32'h0);
    // random commits two idle cycles apart, each followed by a read of the written register
    repeat (8) begin
      iss(1'b1, 1'($urandom), 1'b0, 1'b0, 8'h00);
      chk({resultValid, resultInvalid, resultNumeric, resultMemFault}, 4'h8);
      chk({tagWord, stackTop}, 19'h0);
      @(posedge clock);
      #1 chk(simdRdData, {16'hffff, issueData});
    end
    iss(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    chk(tagWord, 16'hffff);
    $display("test commit done");
    foreach (cv[k]) begin
      wr(8'h00, {29'h0, cv[k]});
      for (int i = 0; i < 22; i++) begin
        iss(1'b1, i[0], 1'b0, 1'b0, pfx[i/2]);
        ev = vecFor(pfx[i/2], i[0], cv[k]);
        chk(resultVector, ev);
        if (ev == 8'h00 && i[0]) chk(resultSegSelect, segFor(pfx[i/2]));
        if (ev == 8'h00 && i[0]) chk(resultUseAddrSize, pfx[i/2] == 8'h67);
      end
    end
    wr(8'h00, 32'h2);
    $display("test prefix done");
    fd = {$urandom, $urandom, 16'h1234};
    issueDstIdx <= 3'h5;
    psx_fpu_model_i.load(3'h5, fd, 16'h5a5a);
    @(posedge clock);
    #1 chk({simdRdData, tagWord, stackTop}, {fd, 16'h5a5a, 3'h5});
    psx_fpu_model_i.pulse(1'b1, 1'b0);
    // pending stays set across two faults; the faulted ops leave the tags alone
    repeat (2) begin
      iss(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      chk({resultVector, resultNumeric, fp_error_out_n}, {8'h10, 2'b10});
      chk(tagWord, 16'h5a5a);
    end
    psx_fpu_model_i.pulse(1'b0, 1'b1);
    iss(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    chk({resultVector, resultValid, fp_error_out_n, tagWord}, {8'h00, 2'b11, 16'h0});
    iss(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    chk({resultMemFault, resultMemKind, resultVector}, {1'b1, issueMemFaultKind, 8'h00});
    $display("test exception done");
    wr(8'h0c, 32'hf);
    wr(8'h08, 32'h0);
    iss(1'b0, 1'b0, 1'b0, 1'b0, 8'hf0);
    chk(irq, 1'b0);
    wr(8'h08, 32'h1);
    #1 chk(irq, 1'b1);
    rd(8'h04);
    chk(rv[0], 1'b1);
    wr(8'h0c, 32'h1);
    #1 chk(irq, 1'b0);
    $display("test interrupt done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
